// [rtl/ccr_pkg.sv]
// constants, types and field layout of the core control register block
// Notes on behaviour
// - bit 12 set selects unsigned multiplier operands
// - writing one to bit 11 ends loop early
// - early loop exit bit always reads zero
// - bits 10..8 report active loop count
// - bit 7 enables accumulator A saturation
// - bit 6 enables accumulator B saturation
// - bit 5 enables write saturation, resets one
// - bit 4 selects super or normal saturation
// - bit 3 shows priority above seven, clear only
// - priority level is bit 3 over status 7..5
// - bit 2 opens program window in data space
// - bit 1 selects conventional or convergent rounding
// - bit 0 selects integer or fractional multiply
// - bits 15..13 always read zero
package ccr_pkg;

    // ----------------------------------------
    // bus and register map
    // ----------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;
    localparam logic [ADDR_W-1:0] CORE_CONTROL_OFFSET = 8'h00;
    localparam logic [DATA_W-1:0] CORE_CONTROL_RESET = 16'h0020;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int BIT_MUL_UNSIGNED = 12;
    localparam int BIT_EARLY_EXIT = 11;
    localparam int BIT_DEPTH_HI = 10;
    localparam int BIT_DEPTH_LO = 8;
    localparam int BIT_ACC_A_SAT = 7;
    localparam int BIT_ACC_B_SAT = 6;
    localparam int BIT_WRITE_SAT = 5;
    localparam int BIT_SUPER_SAT = 4;
    localparam int BIT_PRIO3 = 3;
    localparam int BIT_PROG_WIN = 2;
    localparam int BIT_CONV_ROUND = 1;
    localparam int BIT_INT_MODE = 0;
    localparam int STATUS_PRIO_HI = 7;
    localparam int STATUS_PRIO_LO = 5;

    // ----------------------------------------
    // loop depth
    // ----------------------------------------
    localparam int DEPTH_W = 3;
    localparam logic [DEPTH_W-1:0] DEPTH_MAX = 3'h7;
    localparam logic [DEPTH_W-1:0] DEPTH_ZERO = 3'h0;

    // ----------------------------------------
    // types
    // ----------------------------------------
    typedef enum logic [0:0] {
        EXIT_IDLE = 1'b0,
        EXIT_ARMED = 1'b1
    } ccr_exit_state_t;

    typedef struct packed {
        logic mulUnsigned;
        logic accASatEn;
        logic accBSatEn;
        logic writeSatEn;
        logic superSatMode;
        logic progWindowEn;
        logic conventionalRound;
        logic integerMode;
    } ccr_dsp_cfg_t;

endpackage

// [rtl/ccr_loop_depth.sv]
// active hardware loop nesting counter
`timescale 1ns/1ps
module ccr_loop_depth
    import ccr_pkg::*;
#(
    parameter int WIDTH = DEPTH_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic loopPush,
    input wire logic loopPop,
    output logic [WIDTH-1:0] depth
);

    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);
    localparam logic [WIDTH-1:0] FULL = {WIDTH{1'b1}};

    // ----------------------------------------
    // counter, saturating at both ends
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            depth <= '0;
        end else if (loopPush && !loopPop && depth != FULL) begin
            depth <= depth + ONE;
        end else if (loopPop && !loopPush && depth != '0) begin
            depth <= depth - ONE;
        end
    end

endmodule

// [rtl/ccr_prio_level.sv]
// clear-only priority bit and four-bit priority level
`timescale 1ns/1ps
module ccr_prio_level
    import ccr_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic prioHighSet,
    input wire logic prioHighClr,
    input wire logic swClear,
    input wire logic [2:0] cpuPrioLowBits,
    output logic cpuPrioBit3,
    output logic [3:0] cpuPrioLevel
);

    // ----------------------------------------
    // flag: hardware set wins over any clear
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cpuPrioBit3 <= 1'b0;
        end else if (prioHighSet) begin
            cpuPrioBit3 <= 1'b1;
        end else if (prioHighClr || swClear) begin
            cpuPrioBit3 <= 1'b0;
        end
    end

    // ----------------------------------------
    // level formed from flag and status bits
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cpuPrioLevel <= 4'h0;
        end else begin
            cpuPrioLevel <= {cpuPrioBit3, cpuPrioLowBits};
        end
    end

endmodule

// [rtl/ccr_core_control.sv]
// core control register: dsp configuration, loop and priority status
//
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ps
module ccr_core_control
    import ccr_pkg::*;
#(
    parameter int AW = ADDR_W
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic [AW-1:0] regAddr,
    input wire logic [DATA_W-1:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [DATA_W-1:0] regRdData,
    input wire logic loopPush,
    input wire logic loopPop,
    input wire logic loopIterEnd,
    output logic loopExit,
    input wire logic prioHighSet,
    input wire logic prioHighClr,
    input wire logic [DATA_W-1:0] cpuStatusReg,
    output logic [3:0] cpuPrioLevel,
    output logic [DEPTH_W-1:0] loopNestDepth,
    output ccr_dsp_cfg_t dspCfg
);

    // ----------------------------------------
    // decode
    // ----------------------------------------
    logic hit;
    logic wrHit;
    logic rdHit;
    logic wrExit;
    logic swPrioClear;

    assign hit = (regAddr == AW'(CORE_CONTROL_OFFSET));
    assign wrHit = regWrite && hit;
    assign rdHit = regRead && hit;
    assign wrExit = wrHit && regWrData[BIT_EARLY_EXIT];
    assign swPrioClear = wrHit && !regWrData[BIT_PRIO3];

    // ----------------------------------------
    // writable configuration bits
    // ----------------------------------------
    logic mulUnsigned;
    logic accASatEn;
    logic accBSatEn;
    logic writeSatEn;
    logic superSatMode;
    logic progWindowEn;
    logic conventionalRound;
    logic integerMode;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            mulUnsigned <= CORE_CONTROL_RESET[BIT_MUL_UNSIGNED];
        end else if (wrHit) begin
            mulUnsigned <= regWrData[BIT_MUL_UNSIGNED];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            accASatEn <= CORE_CONTROL_RESET[BIT_ACC_A_SAT];
            accBSatEn <= CORE_CONTROL_RESET[BIT_ACC_B_SAT];
            writeSatEn <= CORE_CONTROL_RESET[BIT_WRITE_SAT];
            superSatMode <= CORE_CONTROL_RESET[BIT_SUPER_SAT];
        end else if (wrHit) begin
            accASatEn <= regWrData[BIT_ACC_A_SAT];
            accBSatEn <= regWrData[BIT_ACC_B_SAT];
            writeSatEn <= regWrData[BIT_WRITE_SAT];
            superSatMode <= regWrData[BIT_SUPER_SAT];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            progWindowEn <= CORE_CONTROL_RESET[BIT_PROG_WIN];
        end else if (wrHit) begin
            progWindowEn <= regWrData[BIT_PROG_WIN];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            conventionalRound <= CORE_CONTROL_RESET[BIT_CONV_ROUND];
            integerMode <= CORE_CONTROL_RESET[BIT_INT_MODE];
        end else if (wrHit) begin
            conventionalRound <= regWrData[BIT_CONV_ROUND];
            integerMode <= regWrData[BIT_INT_MODE];
        end
    end

    // ----------------------------------------
    // configuration outputs
    // ----------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dspCfg <= '0;
            dspCfg.writeSatEn <= CORE_CONTROL_RESET[BIT_WRITE_SAT];
        end else begin
            dspCfg.mulUnsigned <= mulUnsigned;
            dspCfg.accASatEn <= accASatEn;
            dspCfg.accBSatEn <= accBSatEn;
            dspCfg.writeSatEn <= writeSatEn;
            dspCfg.superSatMode <= superSatMode;
            dspCfg.progWindowEn <= progWindowEn;
            dspCfg.conventionalRound <= conventionalRound;
            dspCfg.integerMode <= integerMode;
        end
    end

    // ----------------------------------------
    // loop nesting depth, hardware only
    // ----------------------------------------
    logic [DEPTH_W-1:0] depth;

    ccr_loop_depth #(
        .WIDTH(DEPTH_W)
    ) u_depth (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .loopPush(loopPush),
        .loopPop(loopPop),
        .depth(depth)
    );

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            loopNestDepth <= DEPTH_ZERO;
        end else begin
            loopNestDepth <= depth;
        end
    end

    // ----------------------------------------
    // early loop exit
    // ----------------------------------------
    ccr_exit_state_t exitState;
    ccr_exit_state_t next_exitState;
    logic exitWanted;

    assign exitWanted = (exitState == EXIT_ARMED) || (wrExit && depth != DEPTH_ZERO);

    always_comb begin
        next_exitState = exitState;
        case (exitState)
            EXIT_IDLE: begin
                if (wrExit && depth != DEPTH_ZERO && !loopIterEnd) begin
                    next_exitState = EXIT_ARMED;
                end
            end
            EXIT_ARMED: begin
                if (loopIterEnd || depth == DEPTH_ZERO) begin
                    next_exitState = EXIT_IDLE;
                end
            end
            default: begin
                next_exitState = EXIT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            exitState <= EXIT_IDLE;
        end else begin
            exitState <= next_exitState;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            loopExit <= 1'b0;
        end else begin
            loopExit <= exitWanted && loopIterEnd;
        end
    end

    // ----------------------------------------
    // priority bit and level
    // ----------------------------------------
    logic prioBit3;

    ccr_prio_level u_prio (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .prioHighSet(prioHighSet),
        .prioHighClr(prioHighClr),
        .swClear(swPrioClear),
        .cpuPrioLowBits(cpuStatusReg[STATUS_PRIO_HI:STATUS_PRIO_LO]),
        .cpuPrioBit3(prioBit3),
        .cpuPrioLevel(cpuPrioLevel)
    );

    // ----------------------------------------
    // read path
    // ----------------------------------------
    logic [DATA_W-1:0] readWord;

    always_comb begin
        readWord = '0;
        readWord[BIT_MUL_UNSIGNED] = mulUnsigned;
        readWord[BIT_EARLY_EXIT] = 1'b0;
        readWord[BIT_DEPTH_HI:BIT_DEPTH_LO] = depth;
        readWord[BIT_ACC_A_SAT] = accASatEn;
        readWord[BIT_ACC_B_SAT] = accBSatEn;
        readWord[BIT_WRITE_SAT] = writeSatEn;
        readWord[BIT_SUPER_SAT] = superSatMode;
        readWord[BIT_PRIO3] = prioBit3;
        readWord[BIT_PROG_WIN] = progWindowEn;
        readWord[BIT_CONV_ROUND] = conventionalRound;
        readWord[BIT_INT_MODE] = integerMode;
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            regRdData <= '0;
        end else if (rdHit) begin
            regRdData <= readWord;
        end else begin
            regRdData <= '0;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    a_read_exit_zero: assert property (
        regRead |=> !regRdData[BIT_EARLY_EXIT])
        else $error("early exit bit read as one");

    a_read_top_zero: assert property (
        regRead |=> regRdData[15:13] == 3'h0)
        else $error("unimplemented bits read nonzero");

    a_exit_on_iter: assert property (
        (exitState == EXIT_ARMED && loopIterEnd) |=> loopExit ##1 !loopExit)
        else $error("armed exit did not fire at iteration end");

    a_exit_needs_cause: assert property (
        loopExit |-> $past(loopIterEnd) && $past(exitWanted))
        else $error("loop exit without request");

    a_depth_no_write: assert property (
        (wrHit && !loopPush && !loopPop) |=> $stable(depth))
        else $error("software write changed loop depth");

    a_depth_track: assert property (
        (loopPush && !loopPop && depth != DEPTH_MAX) |=> depth == $past(depth) + 3'h1)
        else $error("loop depth did not count up");

    a_mul_sign_cfg: assert property (
        wrHit |=> ##1 dspCfg.mulUnsigned == $past(regWrData[BIT_MUL_UNSIGNED], 2))
        else $error("multiply sign select not applied");

    a_sat_cfg: assert property (
        wrHit |=> ##1 dspCfg.accASatEn == $past(regWrData[BIT_ACC_A_SAT], 2)
            && dspCfg.accBSatEn == $past(regWrData[BIT_ACC_B_SAT], 2))
        else $error("accumulator saturation enable not applied");

    a_mode_cfg: assert property (
        wrHit |=> ##1 dspCfg.superSatMode == $past(regWrData[BIT_SUPER_SAT], 2)
            && dspCfg.integerMode == $past(regWrData[BIT_INT_MODE], 2)
            && dspCfg.conventionalRound == $past(regWrData[BIT_CONV_ROUND], 2)
            && dspCfg.progWindowEn == $past(regWrData[BIT_PROG_WIN], 2))
        else $error("mode select not applied");

    a_write_sat_reset: assert property (
        $rose(rst_n) |-> writeSatEn && dspCfg.writeSatEn)
        else $error("write saturation not set after reset");

    a_prio_set_wins: assert property (
        prioHighSet |=> prioBit3)
        else $error("priority bit set was lost");

    a_prio_sw_clear: assert property (
        (swPrioClear && !prioHighSet) |=> !prioBit3)
        else $error("priority bit not cleared by write");

    a_prio_level: assert property (
        rst_n |=> cpuPrioLevel == {$past(prioBit3), $past(cpuStatusReg[STATUS_PRIO_HI:STATUS_PRIO_LO])})
        else $error("priority level formed wrongly");

    a_prio_hw_clear: assert property (
        (prioHighClr && !prioHighSet) |=> !prioBit3)
        else $error("priority bit not cleared by core");

    a_read_prio: assert property (
        rdHit |=> regRdData[BIT_PRIO3] == $past(prioBit3))
        else $error("priority bit read wrongly");

    a_read_depth: assert property (
        rdHit |=> regRdData[BIT_DEPTH_HI:BIT_DEPTH_LO] == $past(depth))
        else $error("loop depth read wrongly");

    a_depth_pop: assert property (
        (loopPop && !loopPush && depth != DEPTH_ZERO) |=> depth == $past(depth) - 3'h1)
        else $error("loop depth did not count down");

    a_nest_depth_out: assert property (
        rst_n |=> loopNestDepth == $past(depth))
        else $error("loop depth output does not follow counter");

    a_exit_no_depth: assert property (
        (exitState == EXIT_IDLE && wrExit && depth == DEPTH_ZERO) |=> exitState == EXIT_IDLE && !loopExit)
        else $error("early exit armed with no active loop");

    a_read_mul_sign: assert property (
        rdHit |=> regRdData[BIT_MUL_UNSIGNED] == $past(mulUnsigned))
        else $error("multiply sign select read wrongly");

    a_read_sat_bits: assert property (
        rdHit |=> regRdData[BIT_ACC_A_SAT] == $past(accASatEn) && regRdData[BIT_ACC_B_SAT] == $past(accBSatEn))
        else $error("saturation enables read wrongly");

    a_write_sat_cfg: assert property (
        wrHit |=> ##1 dspCfg.writeSatEn == $past(regWrData[BIT_WRITE_SAT], 2))
        else $error("write saturation enable not applied");

    a_prog_win_cfg: assert property (
        wrHit |=> ##1 dspCfg.progWindowEn == $past(regWrData[BIT_PROG_WIN], 2))
        else $error("program window enable not applied");

    a_round_cfg: assert property (
        wrHit |=> ##1 dspCfg.conventionalRound == $past(regWrData[BIT_CONV_ROUND], 2))
        else $error("rounding select not applied");

    a_int_mode_cfg: assert property (
        wrHit |=> ##1 dspCfg.integerMode == $past(regWrData[BIT_INT_MODE], 2))
        else $error("integer mode select not applied");

    c_early_exit: cover property (wrExit ##[1:20] loopExit);
    c_prio_above: cover property (cpuPrioLevel[3]);
    c_depth_full: cover property (depth == DEPTH_MAX);
    c_prio_clear: cover property (prioBit3 ##1 swPrioClear ##1 !prioBit3);
    c_read_back: cover property (rdHit ##1 regRdData != '0);

endmodule

// [bench/tb.sv]
// self-checking testbench for the core control register block
`timescale 1ns/1ps
module tb
    import ccr_pkg::*;
();
    `define CHK(got, exp) begin nCompared++; if ((got) !== (exp)) begin nErrors++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end

    // ----------------------------------------
    // signals and design instance
    // ----------------------------------------
    logic clk_sys;
    logic rst_n;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData;
    logic regWrite;
    logic regRead;
    logic [DATA_W-1:0] regRdData;
    logic loopPush;
    logic loopPop;
    logic loopIterEnd;
    logic loopExit;
    logic prioHighSet;
    logic prioHighClr;
    logic [DATA_W-1:0] cpuStatusReg;
    logic [3:0] cpuPrioLevel;
    logic [DEPTH_W-1:0] loopNestDepth;
    ccr_dsp_cfg_t dspCfg;
    int nErrors = 0;
    int nCompared = 0;
    int fieldPos[8] = '{BIT_MUL_UNSIGNED, BIT_ACC_A_SAT, BIT_ACC_B_SAT, BIT_WRITE_SAT,
                        BIT_SUPER_SAT, BIT_PROG_WIN, BIT_CONV_ROUND, BIT_INT_MODE};

    ccr_core_control #(.AW(ADDR_W)) u_ccr_core_control (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .regAddr(regAddr),
        .regWrData(regWrData),
        .regWrite(regWrite),
        .regRead(regRead),
        .regRdData(regRdData),
        .loopPush(loopPush),
        .loopPop(loopPop),
        .loopIterEnd(loopIterEnd),
        .loopExit(loopExit),
        .prioHighSet(prioHighSet),
        .prioHighClr(prioHighClr),
        .cpuStatusReg(cpuStatusReg),
        .cpuPrioLevel(cpuPrioLevel),
        .loopNestDepth(loopNestDepth),
        .dspCfg(dspCfg)
    );

    always #20 clk_sys = ~clk_sys;

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("compared %0d, errors %0d", nCompared, nErrors);
        if (nErrors == 0 && nCompared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        regAddr <= a;
        regWrData <= d;
        regWrite <= 1'b1;
        @(posedge clk_sys);
        regWrite <= 1'b0;
    endtask

    task automatic rdChk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
        @(posedge clk_sys);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk_sys);
        regRead <= 1'b0;
        #1;
        `CHK(regRdData, exp)
    endtask

    // which: 0 push, 1 pop, 3 priority set, 4 priority clear
    task automatic pulse(input int which, input int n);
        repeat (n) begin
            @(posedge clk_sys);
            case (which)
                0: loopPush <= 1'b1;
                1: loopPop <= 1'b1;
                3: prioHighSet <= 1'b1;
                default: prioHighClr <= 1'b1;
            endcase
        end
        @(posedge clk_sys);
        loopPush <= 1'b0;
        loopPop <= 1'b0;
        prioHighSet <= 1'b0;
        prioHighClr <= 1'b0;
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    // one iteration end, then exit pulse expected or not, one cycle wide
    task automatic iterChk(input logic exp);
        @(posedge clk_sys);
        loopIterEnd <= 1'b1;
        @(posedge clk_sys);
        loopIterEnd <= 1'b0;
        #1;
        `CHK(loopExit, exp)
        @(posedge clk_sys);
        #1;
        `CHK(loopExit, 1'b0)
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        clk_sys = 1'b0;
        rst_n = 1'b0;
        regAddr = 8'h00;
        regWrData = 16'h0000;
        regWrite = 1'b0;
        regRead = 1'b0;
        loopPush = 1'b0;
        loopPop = 1'b0;
        loopIterEnd = 1'b0;
        prioHighSet = 1'b0;
        prioHighClr = 1'b0;
        cpuStatusReg = 16'h00a0;
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        #1;
        `CHK(dspCfg, 8'h10)
        rdChk(CORE_CONTROL_OFFSET, CORE_CONTROL_RESET);
        @(posedge clk_sys);
        #1;
        `CHK(regRdData, 16'h0000)
        wr(CORE_CONTROL_OFFSET, 16'hffff);
        rdChk(CORE_CONTROL_OFFSET, 16'h10f7);
        settle();
        `CHK(dspCfg, 8'hff)
        for (int i = 0; i < 8; i++) begin
            wr(CORE_CONTROL_OFFSET, 16'h0001 << fieldPos[i]);
            rdChk(CORE_CONTROL_OFFSET, 16'h0001 << fieldPos[i]);
            settle();
            `CHK(dspCfg, 8'h80 >> i)
        end
        wr(8'h02, 16'hffff);
        rdChk(8'h02, 16'h0000);
        rdChk(CORE_CONTROL_OFFSET, 16'h0001);
        // loop depth saturates at seven, writes cannot move it
        pulse(0, 9);
        settle();
        `CHK(loopNestDepth, 3'h7)
        rdChk(CORE_CONTROL_OFFSET, 16'h0701);
        wr(CORE_CONTROL_OFFSET, 16'h0000);
        rdChk(CORE_CONTROL_OFFSET, 16'h0700);
        pulse(1, 6);
        settle();
        `CHK(loopNestDepth, 3'h1)
        // early exit request, then plain iteration, then depth zero
        wr(CORE_CONTROL_OFFSET, 16'h0800);
        rdChk(CORE_CONTROL_OFFSET, 16'h0100);
        `CHK(loopExit, 1'b0)
        iterChk(1'b1);
        iterChk(1'b0);
        pulse(1, 1);
        wr(CORE_CONTROL_OFFSET, 16'h0800);
        iterChk(1'b0);
        // priority bit: pin set, write one keeps, write zero clears
        wr(CORE_CONTROL_OFFSET, 16'h0020);
        pulse(3, 1);
        settle();
        rdChk(CORE_CONTROL_OFFSET, 16'h0028);
        `CHK(cpuPrioLevel, 4'hd)
        wr(CORE_CONTROL_OFFSET, 16'h0028);
        rdChk(CORE_CONTROL_OFFSET, 16'h0028);
        wr(CORE_CONTROL_OFFSET, 16'h0020);
        rdChk(CORE_CONTROL_OFFSET, 16'h0020);
        settle();
        `CHK(cpuPrioLevel, 4'h5)
        wr(CORE_CONTROL_OFFSET, 16'h0008);
        rdChk(CORE_CONTROL_OFFSET, 16'h0000);
        pulse(3, 1);
        cpuStatusReg <= 16'hff1f;
        settle();
        `CHK(cpuPrioLevel, 4'h8)
        pulse(4, 1);
        cpuStatusReg <= 16'h00e0;
        settle();
        rdChk(CORE_CONTROL_OFFSET, 16'h0000);
        `CHK(cpuPrioLevel, 4'h7)
        // second reset in mid-run
        wr(CORE_CONTROL_OFFSET, 16'h10d7);
        pulse(0, 2);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rdChk(CORE_CONTROL_OFFSET, CORE_CONTROL_RESET);
        settle();
        `CHK(dspCfg, 8'h10)
        `CHK(loopNestDepth, 3'h0)
        complete_run();
    end

    initial begin
        repeat (5000) @(posedge clk_sys);
        nErrors++;
        complete_run();
    end
endmodule
